// >>> design/adc_cvd_result_sequencer.sv
`timescale 1ns/10ps
module adc_cvd_result_sequencer
  import cvd_seq_pkg::*;
(
  input  wire logic          pclk,
  input  wire logic          presetn,
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [11:0]   paddr,
  input  wire logic [31:0]   pwdata,
  output logic [31:0]        prdata,
  output logic               pready,
  output logic               pslverr,
  input  wire logic          special_trigger,
  input  wire logic          comparator_out,
  output analog_ctrl_s       analog_ctrl,
  output logic               sar_bit_trial,
  output logic [2:0]         conversion_clock_select,
  output logic [1:0]         positive_reference_select,
  output logic               conversion_done_flag
);

  typedef struct packed {
    seq_state_e   state;
    logic [7:0]   ctrl_zero;
    logic [7:0]   ctrl_one;
    logic [6:0]   precharge_cycle_count;
    logic [6:0]   acquisition_cycle_count;
    logic [3:0]   cvd_ctrl;
    logic [9:0]   result0;
    logic [9:0]   result1;
    logic [9:0]   sar;
    logic [3:0]   step;
    logic [6:0]   timer;
    logic [3:0]   div;
    logic         second_pass;
    logic         done;
    logic         trig_meta;
    logic         trig_sync;
    logic         trig_prev;
    logic         cmp_meta;
    logic         cmp_sync;
    logic [31:0]  rdata;
  } core_s;

  core_s r_reg;
  core_s r_next;

  function automatic logic [7:0] high_byte(input logic [9:0] v,
                                           input logic right);
    high_byte = right ? {6'h00, v[9:8]} : v[9:2];
  endfunction

  function automatic logic [7:0] low_byte(input logic [9:0] v,
                                          input logic right);
    low_byte = right ? v[7:0] : {v[1:0], 6'h00};
  endfunction

  logic       setup_phase;
  logic       wr_en;
  logic       tick;
  logic       right_just;
  logic       invert;
  logic       start_req;
  logic       go_bit;
  logic [9:0] trial;

  assign setup_phase = psel && !penable;
  assign wr_en       = psel && penable && pwrite;
  assign pready      = 1'b1;
  assign right_just  = r_reg.ctrl_one[justify_pos];
  assign go_bit      = r_reg.ctrl_zero[go_pos];
  assign tick        = (r_reg.div == 4'(instr_div_cycles - 1));
  assign invert      = r_reg.second_pass && r_reg.cvd_ctrl[inv_en_pos];
  assign trial       = r_reg.sar | (10'h200 >> (r_reg.step - 4'h1));

  always_comb begin
    logic [7:0] wbyte;
    logic       err;
    wbyte  = pwdata[7:0];
    err    = 1'b0;
    r_next = r_reg;
    r_next.trig_meta = special_trigger;
    r_next.trig_sync = r_reg.trig_meta;
    r_next.trig_prev = r_reg.trig_sync;
    r_next.cmp_meta  = comparator_out;
    r_next.cmp_sync  = r_reg.cmp_meta;
    r_next.div = tick ? 4'h0 : r_reg.div + 4'h1;
    start_req = 1'b0;

    unique case (paddr)
      ctrl_zero_addr:    r_next.rdata = {24'h0, 1'b0, r_reg.ctrl_zero[6:0]};
      ctrl_one_addr:     r_next.rdata = {24'h0, r_reg.ctrl_one & 8'hF3};
      result_high_addr:  r_next.rdata = {24'h0, high_byte(r_reg.result0,
                                                 right_just)};
      result_low_addr:   r_next.rdata = {24'h0, low_byte(r_reg.result0,
                                                right_just)};
      result1_high_addr: r_next.rdata = {24'h0, high_byte(r_reg.result1,
                                                 right_just)};
      result1_low_addr:  r_next.rdata = {24'h0, low_byte(r_reg.result1,
                                                right_just)};
      precharge_addr:    r_next.rdata = {25'h0, r_reg.precharge_cycle_count};
      acquisition_addr:  r_next.rdata = {25'h0, r_reg.acquisition_cycle_count};
      cvd_ctrl_addr:     r_next.rdata = {28'h0, r_reg.cvd_ctrl};
      status_addr:       r_next.rdata = {27'h0, r_reg.done,
                                         r_reg.second_pass, r_reg.state};
      default: begin
        r_next.rdata = 32'h0;
        err = 1'b1;
      end
    endcase
    if (!setup_phase) r_next.rdata = r_reg.rdata;

    if (wr_en) begin
      unique case (paddr)
        ctrl_zero_addr: begin
          r_next.ctrl_zero = {1'b0, wbyte[6:0]};
          if (wbyte[go_pos] && !go_bit) start_req = 1'b1;
        end
        ctrl_one_addr:    r_next.ctrl_one = wbyte & 8'hF3;
        result_high_addr: begin
          if (right_just) r_next.result0[9:8] = wbyte[1:0];
          else r_next.result0[9:2] = wbyte;
        end
        result_low_addr: begin
          if (right_just) r_next.result0[7:0] = wbyte;
          else r_next.result0[1:0] = wbyte[7:6];
        end
        precharge_addr:   r_next.precharge_cycle_count = wbyte[6:0];
        acquisition_addr: r_next.acquisition_cycle_count = wbyte[6:0];
        cvd_ctrl_addr:    r_next.cvd_ctrl = wbyte[3:0];
        status_addr:      r_next.done = r_reg.done & ~wbyte[5];
        default: ;
      endcase
    end
    pslverr = psel && penable && err;

    if (r_reg.trig_sync && !r_reg.trig_prev && !go_bit)
      start_req = 1'b1;

    unique case (r_reg.state)
      st_idle: begin
        r_next.second_pass = 1'b0;
        if (start_req && r_reg.ctrl_zero[power_pos]) begin
          r_next.ctrl_zero[go_pos] = 1'b1;
          // Restart the divider so each phase spans whole instruction cycles
          r_next.div = 4'h0;
          if (r_reg.precharge_cycle_count != 7'h00) begin
            r_next.state = st_precharge;
            r_next.timer = r_reg.precharge_cycle_count;
          end else begin
            r_next.state = st_acquire;
            r_next.timer = r_reg.acquisition_cycle_count;
          end
        end else if (start_req) begin
          r_next.ctrl_zero[go_pos] = 1'b0;
        end
      end
      st_precharge: if (tick) begin
        if (r_reg.timer <= 7'h01) begin
          r_next.state = st_acquire;
          r_next.timer = r_reg.acquisition_cycle_count;
        end else begin
          r_next.timer = r_reg.timer - 7'h01;
        end
      end
      st_acquire: if (tick) begin
        if (r_reg.timer <= 7'h01) begin
          r_next.state = st_convert;
          r_next.sar   = 10'h000;
          r_next.step  = 4'h0;
        end else begin
          r_next.timer = r_reg.timer - 7'h01;
        end
      end
      st_convert: if (tick) begin
        if (r_reg.step != 4'h0) begin
          if (r_reg.cmp_sync) r_next.sar = trial;
        end
        r_next.step = r_reg.step + 4'h1;
        if (r_reg.step == 4'(conv_steps - 1)) begin
          if (r_reg.second_pass) begin
            r_next.result1 = r_next.sar;
          end else begin
            r_next.result0 = r_next.sar;
          end
          if (r_reg.cvd_ctrl[dbl_en_pos] && !r_reg.second_pass) begin
            r_next.state       = st_gap;
            r_next.second_pass = 1'b1;
            r_next.timer       = 7'(gap_cycles);
          end else begin
            r_next.state = st_idle;
            r_next.ctrl_zero[go_pos] = 1'b0;
            r_next.done  = 1'b1;
          end
        end
      end
      st_gap: if (tick) begin
        if (r_reg.timer <= 7'h01) begin
          if (r_reg.precharge_cycle_count != 7'h00) begin
            r_next.state = st_precharge;
            r_next.timer = r_reg.precharge_cycle_count;
          end else begin
            r_next.state = st_acquire;
            r_next.timer = r_reg.acquisition_cycle_count;
          end
        end else begin
          r_next.timer = r_reg.timer - 7'h01;
        end
      end
      default: r_next.state = st_idle;
    endcase

    // Software clearing go or power aborts; the partial value is kept
    if (r_reg.state != st_idle && (!r_next.ctrl_zero[go_pos] ||
        !r_next.ctrl_zero[power_pos]) && r_next.state != st_idle) begin
      r_next.state = st_idle;
      r_next.ctrl_zero[go_pos] = 1'b0;
      if (r_reg.state == st_convert) begin
        if (r_reg.second_pass) r_next.result1 = r_reg.sar;
        else r_next.result0 = r_reg.sar;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_reg <= '{state: st_idle, ctrl_zero: ctrl_zero_rst,
                 ctrl_one: ctrl_one_rst, precharge_cycle_count: count_rst,
                 acquisition_cycle_count: count_rst,
                 cvd_ctrl: cvd_ctrl_rst, result0: result_rst,
                 result1: result_rst, default: '0};
    end else begin
      r_reg <= r_next;
    end
  end

  // Capacitor and sensor bias are steered only here; no discharge path
  // exists after conversion, so charge carries into the next acquisition.
  always_comb begin
    analog_ctrl.channel          = r_reg.ctrl_zero[6:2];
    analog_ctrl.cap_bias_on      = (r_reg.state == st_precharge);
    analog_ctrl.sensor_drive_on  = (r_reg.state == st_precharge);
    analog_ctrl.cap_to_supply    = r_reg.cvd_ctrl[int_pol_pos] ^ invert;
    analog_ctrl.sensor_to_supply = r_reg.cvd_ctrl[ext_pol_pos] ^ invert;
    analog_ctrl.cap_connect      = (r_reg.state != st_precharge);
    analog_ctrl.convert_active   = (r_reg.state == st_convert);
  end

  assign sar_bit_trial             = (r_reg.state == st_convert);
  assign conversion_clock_select   = r_reg.ctrl_one[6:4];
  assign positive_reference_select = r_reg.ctrl_one[1:0];
  assign conversion_done_flag      = r_reg.done;
  assign prdata                    = r_reg.rdata;

endmodule

// >>> design/cvd_seq_pkg.sv
package cvd_seq_pkg;

  // Register byte addresses on the APB bus
  localparam logic [11:0] ctrl_zero_addr   = 12'h000;
  localparam logic [11:0] ctrl_one_addr    = 12'h004;
  localparam logic [11:0] result_high_addr = 12'h008;
  localparam logic [11:0] result_low_addr  = 12'h00C;
  localparam logic [11:0] result1_high_addr = 12'h010;
  localparam logic [11:0] result1_low_addr = 12'h014;
  localparam logic [11:0] precharge_addr   = 12'h018;
  localparam logic [11:0] acquisition_addr = 12'h01C;
  localparam logic [11:0] cvd_ctrl_addr    = 12'h020;
  localparam logic [11:0] status_addr      = 12'h024;

  // Field positions
  localparam int chan_lsb_pos    = 2;
  localparam int go_pos          = 1;
  localparam int power_pos       = 0;
  localparam int justify_pos     = 7;
  localparam int clk_sel_lsb_pos = 4;
  localparam int vref_lsb_pos    = 0;
  localparam int int_pol_pos     = 0;
  localparam int ext_pol_pos     = 1;
  localparam int dbl_en_pos      = 2;
  localparam int inv_en_pos      = 3;

  // Reset values
  localparam logic [7:0] ctrl_zero_rst = 8'h00;
  localparam logic [7:0] ctrl_one_rst  = 8'h00;
  localparam logic [6:0] count_rst     = 7'h00;
  localparam logic [3:0] cvd_ctrl_rst  = 4'h0;
  localparam logic [9:0] result_rst    = 10'h000;

  // One 200 ns instruction cycle is ten 20 ns bus clocks
  localparam int instr_cycle_ns = 200;
  localparam int clk_period_ns  = 20;
  localparam int instr_div_cycles = instr_cycle_ns / clk_period_ns;
  // Converter bit time in instruction cycles; 10 bits plus one sample slot
  localparam int conv_bit_cycles  = 1;
  localparam int conv_steps       = 11;
  // Second pass starts two instruction cycles after the first ends
  localparam int gap_cycles       = 2;

  typedef enum logic [2:0] {
    st_idle, st_precharge, st_acquire, st_convert, st_gap
  } seq_state_e;

  typedef struct packed {
    logic       cap_to_supply;
    logic       sensor_to_supply;
    logic       cap_bias_on;
    logic       sensor_drive_on;
    logic       cap_connect;
    logic       convert_active;
    logic [4:0] channel;
  } analog_ctrl_s;

endpackage

// >>> dv/adc_cvd_asserts.sv
`timescale 1ns/10ps
module adc_cvd_asserts
  import cvd_seq_pkg::*;
(
  input wire logic         pclk,
  input wire logic         presetn,
  input wire logic         psel,
  input wire logic         penable,
  input wire logic         pwrite,
  input wire logic [11:0]  paddr,
  input wire logic [31:0]  pwdata,
  input wire analog_ctrl_s analog_ctrl,
  input wire logic         sar_bit_trial,
  input wire logic         conversion_done_flag
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic        clear_wr;
  logic [10:0] pre_cnt_reg;
  assign clear_wr = psel && penable && pwrite && paddr == status_addr
                    && pwdata[5];
  // Bias pulse width, so a cut-short tick shows up
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_cnt_reg <= '0;
    end else begin
      pre_cnt_reg <= analog_ctrl.cap_bias_on ? pre_cnt_reg + 11'h001 : '0;
    end
  end
  sequence pre_end; $fell(analog_ctrl.cap_bias_on); endsequence
  sequence conv_start; $rose(sar_bit_trial); endsequence
  sequence done_rise; $rose(conversion_done_flag); endsequence
  AST_ISOLATE: assert property (
    analog_ctrl.cap_bias_on |->
      !analog_ctrl.cap_connect && analog_ctrl.sensor_drive_on)
    else $error("hold capacitor biased while connected");
  AST_RECONNECT: assert property (
    pre_end |-> analog_ctrl.cap_connect && !analog_ctrl.sensor_drive_on)
    else $error("capacitor not reconnected after pre-charge");
  AST_PRE_TICKS: assert property (
    pre_end |-> pre_cnt_reg % instr_div_cycles == 0 && pre_cnt_reg != 0)
    else $error("pre-charge not whole instruction cycles");
  AST_ACQ_GAP: assert property (
    pre_end |-> !sar_bit_trial [*8])
    else $error("conversion began without acquisition");
  AST_CONV_CLEAN: assert property (
    sar_bit_trial |->
      !analog_ctrl.cap_bias_on && !analog_ctrl.sensor_drive_on)
    else $error("bias active during conversion");
  AST_CONV_RUNS: assert property (
    conv_start |-> sar_bit_trial [*8])
    else $error("conversion stopped early");
  AST_DONE_CAUSE: assert property (
    done_rise |-> $past(sar_bit_trial) || $past(sar_bit_trial, 2))
    else $error("done flag set without conversion");
  AST_DONE_STICKY: assert property (
    conversion_done_flag && !clear_wr |=> conversion_done_flag)
    else $error("done flag dropped without clear");
endmodule

bind adc_cvd_result_sequencer adc_cvd_asserts u_asserts (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .analog_ctrl(analog_ctrl), .sar_bit_trial(sar_bit_trial),
  .conversion_done_flag(conversion_done_flag));

// >>> dv/cvd_front_end.sv
`timescale 1ns/10ps
module cvd_front_end
  import cvd_seq_pkg::*;
(
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire analog_ctrl_s analog_ctrl,
  output logic              comparator_out
);
  // Tiny sensor: the held charge alone decides every trial
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      comparator_out <= 1'b0;
    end else if (analog_ctrl.cap_bias_on) begin
      comparator_out <= analog_ctrl.cap_to_supply;
    end
  end
endmodule

// >>> dv/test_adc_cvd_result_sequencer.sv
`timescale 1ns/10ps
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin \
  $display("BAD %s exp %h got %h", n, e, g); bad_count++; end end
module test_adc_cvd_result_sequencer
  import cvd_seq_pkg::*;
;
  logic         pclk, presetn, psel, penable, pwrite, special_trigger;
  logic         pready, pslverr, sar_bit_trial, comparator_out;
  logic         conversion_done_flag;
  logic [11:0]  paddr;
  logic [31:0]  pwdata, prdata;
  logic [32:0]  mon_e;
  logic [2:0]   clk_sel;
  logic [1:0]   vref_sel;
  logic [15:0]  lfsr;
  analog_ctrl_s analog_ctrl;
  int           bad_count, tests_run;
  logic [32:0]  exp_q[$];
  function automatic logic [15:0] lfsr_next(input logic [15:0] v);
    lfsr_next = {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  adc_cvd_result_sequencer dut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .special_trigger(special_trigger), .comparator_out(comparator_out),
    .analog_ctrl(analog_ctrl), .sar_bit_trial(sar_bit_trial),
    .conversion_clock_select(clk_sel), .positive_reference_select(vref_sel),
    .conversion_done_flag(conversion_done_flag));
  cvd_front_end front (.pclk(pclk), .presetn(presetn),
    .analog_ctrl(analog_ctrl), .comparator_out(comparator_out));
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  task automatic apb(input logic w, input logic [11:0] a, input int d);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    psel <= 1'b0; penable <= 1'b0;
  endtask
  // Only word-aligned offsets up to the status register are mapped
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    logic err;
    err = (a > status_addr) || (a[1:0] != 2'b00);
    exp_q.push_back({err, e});
    apb(1'b0, a, 0);
  endtask
  always @(posedge pclk) begin
    if (psel && penable && pready && !pwrite && exp_q.size() > 0) begin
      mon_e = exp_q.pop_front();
      `CHK("prdata", mon_e[31:0], prdata)
      `CHK("pslverr", mon_e[32], pslverr)
    end
  end
  // Times each phase; pre 0 means the bias must never appear and acquisition goes untimed
  task automatic run(input int pre, input int acq);
    int   n;
    int   t_conv;
    logic pb;
    logic pol;
    n = 0;
    pb = 1'b0;
    t_conv = conv_steps * conv_bit_cycles * instr_div_cycles;
    if (pre > 0) begin
      while (analog_ctrl.cap_bias_on !== 1'b1 && n < 200) begin
        @(negedge pclk);
        n++;
      end
      // Every scenario with pre-charge programs the two bias levels opposite
      pol = analog_ctrl.cap_to_supply ^ analog_ctrl.sensor_to_supply;
      `CHK("polarity", 1'b1, pol)
      n = 0;
      while (analog_ctrl.cap_bias_on === 1'b1) begin
        @(negedge pclk);
        n++;
      end
      `CHK("precharge", pre * instr_div_cycles, n)
    end
    n = 0;
    while (sar_bit_trial !== 1'b1 && n < 1500) begin
      @(negedge pclk);
      n++;
      pb |= analog_ctrl.cap_bias_on;
    end
    if (pre > 0) `CHK("acquire", acq * instr_div_cycles, n)
    else `CHK("skip", 1'b0, pb)
    `CHK("active", 1'b1, analog_ctrl.convert_active)
    n = 0;
    while (sar_bit_trial === 1'b1) begin
      @(negedge pclk);
      n++;
    end
    `CHK("convert", t_conv, n)
  endtask
  task automatic setup(input int c1, input int pre,
                       input int acq, input int cv);
    apb(1'b1, status_addr, 32'h20);
    apb(1'b1, ctrl_one_addr, c1);
    apb(1'b1, precharge_addr, pre);
    apb(1'b1, acquisition_addr, acq);
    apb(1'b1, cvd_ctrl_addr, cv);
    apb(1'b1, ctrl_zero_addr, 32'h0D);
    repeat (60) @(posedge pclk);
    `CHK("channel", 5'h03, analog_ctrl.channel)
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h000;
    pwdata = 32'h0; special_trigger = 1'b0; presetn = 1'b0;
    bad_count = 0;
    tests_run = 0;
    lfsr = 16'h6A89;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    rd(ctrl_zero_addr, 32'h0);
    rd(result_high_addr, 32'h0);
    rd(12'h0FC, 32'h0);
    repeat (3) begin
      lfsr = lfsr_next(lfsr);
      apb(1'b1, ctrl_one_addr, {24'h0, lfsr[7:0]});
      rd(ctrl_one_addr, {24'h0, lfsr[7:0] & 8'hF3});
      `CHK("clk_sel", lfsr[6:4], clk_sel)
      `CHK("vref_sel", lfsr[1:0], vref_sel)
    end
    $display("test registers done");
    setup(32'h80, 3, 2, 32'h1);
    apb(1'b1, ctrl_zero_addr, 32'h0F);
    run(3, 2);
    @(negedge pclk);
    `CHK("done", 1'b1, conversion_done_flag)
    rd(ctrl_zero_addr, 32'h0D);
    rd(result_high_addr, 32'h03);
    rd(result_low_addr, 32'hFF);
    $display("test right single done");
    // Pre-charge skipped: only the charge left from before can read high
    setup(32'h00, 0, 2, 32'h0);
    @(negedge pclk);
    `CHK("clear", 1'b0, conversion_done_flag)
    @(posedge pclk);
    special_trigger <= 1'b1;
    repeat (4) @(posedge pclk);
    special_trigger <= 1'b0;
    run(0, 2);
    rd(result_high_addr, 32'hFF);
    rd(result_low_addr, 32'hC0);
    rd(result1_low_addr, 32'h00);
    $display("test left skip done");
    setup(32'h80, 127, 1, 32'hD);
    apb(1'b1, ctrl_zero_addr, 32'h0F);
    run(127, 1);
    run(127, 1);
    rd(result_high_addr, 32'h03);
    rd(result_low_addr, 32'hFF);
    rd(result1_high_addr, 32'h00);
    rd(result1_low_addr, 32'h00);
    $display("test double inverted done");
    stop_test();
  end
  // About ten times the expected run length
  initial begin
    repeat (30000) @(posedge pclk);
    bad_count++;
    stop_test();
  end
endmodule
